// ### src/ebs_bus_master.sv
// ebs_bus_master: external bus master with strobes, handshake end and dynamic sizing
`timescale 1ns/1ps
module ebs_bus_master
    import ebs_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        req_valid_i,
    input  wire ebs_req_t    req_i,
    output logic             req_ready_o,
    output logic             resp_valid_o,
    output ebs_resp_t        resp_o,
    output logic             exception_o,
    output logic [23:0]      address_o,
    output logic             xfer_size_code_hi_o,
    output logic             xfer_size_code_lo_o,
    output logic             read_write_o,
    output logic             address_valid_strobe_n_o,
    output logic             data_valid_strobe_n_o,
    output logic [15:0]      data_o,
    output logic             data_oe_o,
    input  wire logic [15:0] data_i,
    input  wire logic        port_ack_upper_n_i,
    input  wire logic        port_ack_lower_n_i,
    input  wire logic        bus_fault_term_n_i,
    input  wire logic        halt_n_i,
    input  wire logic        auto_vector_term_n_i,
    input  wire logic        monitor_fault_i
);
    ebs_state_t  state;
    ebs_term_t   term;
    logic [2:0]  rem;
    logic [31:0] sh;
    logic [31:0] rd;
    logic [2:0]  moved;
    logic        is_write;
    logic        is_iack;
    logic        op_long;
    logic        op_fault;
    logic        op_vec;
    logic        take;
    logic        illegal;
    logic        ending;
    logic        last;
    logic [2:0]  next_moved;
    logic [15:0] wr_word;
    logic [7:0]  rd_byte;
    logic        byte_lane_select;

    ebs_term_decode u_term (
        .port_ack_upper_n_i   (port_ack_upper_n_i),
        .port_ack_lower_n_i   (port_ack_lower_n_i),
        .bus_fault_term_n_i   (bus_fault_term_n_i),
        .halt_n_i             (halt_n_i),
        .auto_vector_term_n_i (auto_vector_term_n_i),
        .monitor_fault_i      (monitor_fault_i),
        .iack_i               (is_iack),
        .term_o               (term)
    );

    ebs_lane_mux u_lane (
        .byte0_i   (sh[31:24]),
        .byte1_i   (sh[23:16]),
        .rem_i     (rem),
        .a0_i      (byte_lane_select),
        .port16_i  (term.port16),
        .data_i    (data_i),
        .wr_word_o (wr_word),
        .rd_byte_o (rd_byte)
    );

    // request decode and cycle-end terms
    always_comb begin
        byte_lane_select = address_o[0]; // [R18]
        take    = (state == ST_IDLE) && req_valid_i && req_ready_o;
        illegal = !(req_i.nbytes == 3'h1 || req_i.nbytes == 3'h2 || req_i.nbytes == 3'h4)
                  || (req_i.nbytes != 3'h1 && req_i.addr[0]); // [R19]
        ending  = (state == ST_WAIT) && term.done;
        last    = (rem == 3'h0) || op_fault || op_vec;
        // a faulted or auto-vectored cycle moves no operand bytes
        if (term.fault || term.autovec) begin
            next_moved = 3'h0;
        end else begin
            next_moved = ebs_moved(rem, byte_lane_select, term.port16); // [R16] [R17]
        end
    end

    // sequencer: each state but ST_IDLE and ST_WAIT lasts one half bus period
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take && !illegal) begin
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR: state <= ST_STRB;
                ST_STRB: state <= is_write ? ST_WDAT : ST_WAIT;
                ST_WDAT: state <= ST_WAIT;
                ST_WAIT: begin
                    if (term.done) begin // [R8] wait states while nothing ends the cycle
                        state <= ST_END;
                    end
                end
                ST_END:  state <= last ? ST_IDLE : ST_ADDR; // [R24] [R14]
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ready only while idle; a refused request keeps it high
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            req_ready_o <= 1'b0;
        end else begin
            req_ready_o <= ((state == ST_IDLE) && !(take && !illegal))
                           || ((state == ST_END) && last);
        end
    end

    // operand attributes held for the whole operand
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            is_write <= 1'b0;
            is_iack  <= 1'b0;
            op_long  <= 1'b0;
        end else if (take && !illegal) begin
            is_write <= req_i.write;
            is_iack  <= req_i.iack;
            op_long  <= (req_i.nbytes == 3'h4);
        end
    end

    // address and size code: set at each cycle start, kept while strobe is low
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            address_o           <= ADDR_RESET;
            xfer_size_code_hi_o <= SIZE_LONG[1];
            xfer_size_code_lo_o <= SIZE_LONG[0];
        end else if (take && !illegal) begin
            address_o <= req_i.addr; // [R1]
            {xfer_size_code_hi_o, xfer_size_code_lo_o} <= ebs_size_code(req_i.nbytes); // [R23]
        end else if (state == ST_END && !last) begin
            address_o <= address_o + {21'h000000, moved}; // [R24]
            {xfer_size_code_hi_o, xfer_size_code_lo_o} <= ebs_size_code(rem); // [R17] [R22]
        end
    end

    // direction changes only when a new operand needs the other one
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            read_write_o <= 1'b1;
        end else if (take && !illegal) begin
            read_write_o <= !req_i.write;
        end
    end

    // remaining count, left-aligned write bytes so the leading byte goes first
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rem   <= 3'h0;
            sh    <= 32'h00000000;
            moved <= 3'h0;
        end else if (take && !illegal) begin
            rem <= req_i.nbytes;
            case (req_i.nbytes)
                3'h1:    sh <= {req_i.wdata[7:0], 24'h000000};
                3'h2:    sh <= {req_i.wdata[15:0], 16'h0000};
                default: sh <= req_i.wdata; // [R20] most significant word leads
            endcase
        end else if (ending) begin
            moved <= next_moved;
            rem   <= (term.fault || term.autovec) ? 3'h0 : rem - next_moved;
            case (next_moved)
                3'h2:    sh <= {sh[15:0], 16'h0000};
                3'h1:    sh <= {sh[23:0], 8'h00};
                default: sh <= sh;
            endcase
        end
    end

    // read assembly shifts new bytes in at the bottom, so it ends right-aligned
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rd <= 32'h00000000;
        end else if (take && !illegal) begin
            rd <= 32'h00000000;
        end else if (ending && !is_write) begin
            case (next_moved)
                3'h2:    rd <= {rd[15:0], data_i}; // [R3] [R21]
                3'h1:    rd <= {rd[23:0], rd_byte}; // [R3] [R22]
                default: rd <= rd;
            endcase
        end
    end

    // how the operand ended
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            op_fault <= 1'b0;
            op_vec   <= 1'b0;
        end else if (take && !illegal) begin
            op_fault <= 1'b0;
            op_vec   <= 1'b0;
        end else if (ending) begin
            op_fault <= term.fault; // [R10]
            op_vec   <= term.autovec && !term.fault; // [R13]
        end
    end

    // address strobe half a period into the cycle, released when the cycle ends
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            address_valid_strobe_n_o <= 1'b1;
        end else if (state == ST_ADDR) begin
            address_valid_strobe_n_o <= 1'b0; // [R2]
        end else if (ending) begin
            address_valid_strobe_n_o <= 1'b1;
        end
    end

    // data strobe: with the address strobe on reads, one period later on writes
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            data_valid_strobe_n_o <= 1'b1;
        end else if (state == ST_ADDR && !is_write) begin
            data_valid_strobe_n_o <= 1'b0; // [R6]
        end else if (state == ST_WDAT) begin
            data_valid_strobe_n_o <= 1'b0; // [R7]
        end else if (ending) begin
            data_valid_strobe_n_o <= 1'b1;
        end
    end

    // write data: one enable covers all sixteen lines
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            data_o    <= 16'h0000;
            data_oe_o <= 1'b0;
        end else if (state == ST_STRB && is_write) begin
            data_o    <= wr_word; // [R5]
            data_oe_o <= 1'b1; // [R4]
        end else if (ending) begin
            data_oe_o <= 1'b0;
        end
    end

    // answer: one pulse per operand, or at once for a refused one
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            resp_valid_o <= 1'b0;
            resp_o       <= '0;
        end else if (take && illegal) begin
            resp_valid_o    <= 1'b1;
            resp_o          <= '0;
            resp_o.misalign <= 1'b1; // [R19]
        end else if (state == ST_END && last) begin
            resp_valid_o   <= 1'b1;
            resp_o.rdata   <= rd;
            resp_o.fault   <= op_fault;
            resp_o.autovec <= op_vec;
            resp_o.misalign <= 1'b0;
        end else begin
            resp_valid_o <= 1'b0;
        end
    end

    // exception pulse when fault and halt terminate together
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            exception_o <= 1'b0;
        end else begin
            exception_o <= ending && term.halt_exc; // [R12]
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    property p_addr_stable;
        !address_valid_strobe_n_o && $past(!address_valid_strobe_n_o) |-> $stable(address_o);
    endproperty
    a_addr_stable: assert property (p_addr_stable) // [R1]
        else $error("address moved while address strobe low");

    property p_as_delay;
        $fell(address_valid_strobe_n_o) |-> $past(state == ST_ADDR);
    endproperty
    a_as_delay: assert property (p_as_delay) // [R2]
        else $error("address strobe not half a period after cycle start");

    property p_rd_ds;
        $fell(address_valid_strobe_n_o) && read_write_o |-> $fell(data_valid_strobe_n_o);
    endproperty
    a_rd_ds: assert property (p_rd_ds) // [R6]
        else $error("read data strobe not with address strobe");

    property p_wr_ds;
        $fell(address_valid_strobe_n_o) && !read_write_o
            |-> data_valid_strobe_n_o ##1 data_valid_strobe_n_o ##1 !data_valid_strobe_n_o;
    endproperty
    a_wr_ds: assert property (p_wr_ds) // [R7]
        else $error("write data strobe not one period after address strobe");

    property p_wr_data;
        $fell(address_valid_strobe_n_o) && !read_write_o |-> !data_oe_o ##1 data_oe_o;
    endproperty
    a_wr_data: assert property (p_wr_data) // [R5]
        else $error("write data not half a period after address strobe");

    property p_wr_drive;
        !data_valid_strobe_n_o && !read_write_o |-> data_oe_o;
    endproperty
    a_wr_drive: assert property (p_wr_drive) // [R4]
        else $error("write data strobe without driven data");

    property p_three;
        !address_valid_strobe_n_o && xfer_size_code_hi_o && xfer_size_code_lo_o |-> op_long;
    endproperty
    a_three: assert property (p_three) // [R22]
        else $error("three-byte size code outside a long word");

    property p_wait;
        state == ST_WAIT && port_ack_upper_n_i && port_ack_lower_n_i && bus_fault_term_n_i
            && !monitor_fault_i && (auto_vector_term_n_i || !is_iack) |=> state == ST_WAIT;
    endproperty
    a_wait: assert property (p_wait) // [R9]
        else $error("cycle ended without termination");

    property p_refuse;
        take && req_i.nbytes == 3'h2 && req_i.addr[0]
            |=> resp_valid_o && resp_o.misalign && address_valid_strobe_n_o;
    endproperty
    a_refuse: assert property (p_refuse) // [R19]
        else $error("misaligned word was not refused");

    property p_exc;
        state == ST_WAIT && !bus_fault_term_n_i && !halt_n_i |=> exception_o;
    endproperty
    a_exc: assert property (p_exc) // [R12]
        else $error("fault with halt gave no exception");

    property p_advance;
        state == ST_END && !last |=> address_o == $past(address_o) + {21'h000000, $past(moved)};
    endproperty
    a_advance: assert property (p_advance) // [R24]
        else $error("follow-on cycle address not advanced");

    c_three: cover property (!address_valid_strobe_n_o && xfer_size_code_hi_o
                             && xfer_size_code_lo_o && !read_write_o);
    c_fault: cover property (resp_valid_o && resp_o.fault);
    c_vec:   cover property (resp_valid_o && resp_o.autovec);
    c_long16: cover property (state == ST_END && !last && moved == 3'h2);
endmodule

// ### src/ebs_pkg.sv
// ebs_pkg: constants, carrier types and helpers of the external bus sizing master
// Summary of operation
// R1 - Drive the 24-bit address of the leading byte, stable while address strobe low.
// R2 - Assert address strobe half a bus clock after the cycle starts.
// R3 - Read data is captured on the last edge of the bus cycle.
// R4 - Write cycles drive all sixteen data lines regardless of size or port.
// R5 - Write data appears half a bus clock after address strobe.
// R6 - Read cycles assert data strobe together with address strobe.
// R7 - Write cycles assert data strobe one bus clock after address strobe.
// R8 - Port acknowledges end each cycle; reads capture data, writes mean data stored.
// R9 - Acknowledge pair: both high waits, lower low 8-bit, upper low 16-bit, both reserved.
// R10 - Bus fault input terminates a cycle, alone or together with acknowledges.
// R11 - Internal bus monitor can raise the bus fault termination.
// R12 - Bus fault with halt together raises a bus error exception.
// R13 - Auto-vector ends interrupt acknowledge cycles only; ignored in all others.
// R14 - Long word takes two cycles on 16-bit port, four on 8-bit port.
// R15 - External 16-bit port uses all lanes, 8-bit port only the upper lane.
// R16 - Every cycle starts assuming a 16-bit port, moving as much as possible.
// R17 - Size code gives remaining bytes; fewer may move depending on port width.
// R18 - Upper address bits give word base; lowest bit gives byte offset and steers lanes.
// R19 - Word and long-word operands at odd addresses are refused, never transferred.
// R20 - Long word through 16-bit port moves most significant word first.
// R21 - Byte lanes: odd byte on lower lane for 16-bit, upper otherwise.
// R22 - Reads ignore the duplicate lane; three-byte code only for long word to 8-bit.
// R23 - Size codes: 01 byte, 10 word, 11 three bytes, 00 long word.
// R24 - A partial cycle is followed by one with advanced address and reduced size.
package ebs_pkg;
    // bus clock runs at half of clock_i, so one bus half period is one clock cycle
    localparam int         CLK_PERIOD_NS   = 25;
    localparam int         BUS_HALF_NS     = 25;
    localparam int         BUS_HALF_CYCLES = (BUS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] SIZE_BYTE       = 2'h1;
    localparam logic [1:0] SIZE_WORD       = 2'h2;
    localparam logic [1:0] SIZE_THREE      = 2'h3;
    localparam logic [1:0] SIZE_LONG       = 2'h0;
    localparam logic [1:0] ACK_WAIT        = 2'h3;
    localparam logic [1:0] ACK_PORT8       = 2'h2;
    localparam logic [1:0] ACK_PORT16      = 2'h1;
    localparam logic [1:0] ACK_RESERVED    = 2'h0;
    localparam logic [23:0] ADDR_RESET     = 24'h000000;

    typedef struct packed {
        logic [23:0] addr;
        logic [2:0]  nbytes;
        logic        write;
        logic        iack;
        logic [31:0] wdata;
    } ebs_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        fault;
        logic        autovec;
        logic        misalign;
    } ebs_resp_t;

    typedef struct packed {
        logic done;
        logic port16;
        logic fault;
        logic halt_exc;
        logic autovec;
    } ebs_term_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_STRB = 6'h04,
        ST_WDAT = 6'h08,
        ST_WAIT = 6'h10,
        ST_END  = 6'h20
    } ebs_state_t;

    // size code for the bytes still to move
    function automatic logic [1:0] ebs_size_code(input logic [2:0] rem);
        case (rem)
            3'h1:    ebs_size_code = SIZE_BYTE;
            3'h2:    ebs_size_code = SIZE_WORD;
            3'h3:    ebs_size_code = SIZE_THREE;
            default: ebs_size_code = SIZE_LONG;
        endcase
    endfunction

    // bytes one cycle moves: a word only when even, at least two left and the port is 16 bits
    function automatic logic [2:0] ebs_moved(input logic [2:0] rem,
                                             input logic       a0,
                                             input logic       port16);
        ebs_moved = (!a0 && port16 && rem >= 3'h2) ? 3'h2 : 3'h1;
    endfunction
endpackage

// ### src/ebs_term_decode.sv
// ebs_term_decode: turns the termination inputs into one cycle-end decision
`timescale 1ns/1ps
module ebs_term_decode
    import ebs_pkg::*;
(
    input  wire logic      port_ack_upper_n_i,
    input  wire logic      port_ack_lower_n_i,
    input  wire logic      bus_fault_term_n_i,
    input  wire logic      halt_n_i,
    input  wire logic      auto_vector_term_n_i,
    input  wire logic      monitor_fault_i,
    input  wire logic      iack_i,
    output ebs_term_t      term_o
);
    logic [1:0] ack;

    // reserved acknowledge pair is treated as a fault so the cycle cannot hang
    always_comb begin
        ack             = {port_ack_upper_n_i, port_ack_lower_n_i};
        term_o.fault    = !bus_fault_term_n_i || monitor_fault_i
                          || (ack == ACK_RESERVED); // [R10] [R11] [R9]
        term_o.halt_exc = !bus_fault_term_n_i && !halt_n_i; // [R12]
        term_o.autovec  = iack_i && !auto_vector_term_n_i; // [R13]
        term_o.port16   = (ack == ACK_PORT16); // [R9] [R16]
        term_o.done     = (ack != ACK_WAIT) || term_o.fault || term_o.autovec; // [R8]
    end
endmodule

// ### src/ebs_lane_mux.sv
// ebs_lane_mux: byte lane routing between operand bytes and the 16-bit data bus
`timescale 1ns/1ps
module ebs_lane_mux (
    input  wire logic [7:0]  byte0_i,
    input  wire logic [7:0]  byte1_i,
    input  wire logic [2:0]  rem_i,
    input  wire logic        a0_i,
    input  wire logic        port16_i,
    input  wire logic [15:0] data_i,
    output logic      [15:0] wr_word_o,
    output logic      [7:0]  rd_byte_o
);
    // a lone byte is copied to both lanes, so either port width finds it
    always_comb begin
        if (!a0_i && rem_i >= 3'h2) begin
            wr_word_o = {byte0_i, byte1_i}; // [R21]
        end else begin
            wr_word_o = {byte0_i, byte0_i}; // [R21]
        end
        // the duplicate lane is dropped on reads
        rd_byte_o = (a0_i && port16_i) ? data_i[7:0] : data_i[15:8]; // [R22] [R15]
    end
endmodule

// ### verif/ebs_mem_model.sv
// ebs_mem_model: behavioural memory, 8-bit port in the upper half of the map, 16-bit below
`timescale 1ns/1ps
module ebs_mem_model (
    input  wire logic        clock_i,
    input  wire logic [23:0] address_i,
    input  wire logic [1:0]  size_i,
    input  wire logic        read_write_i,
    input  wire logic        av_n_i,
    input  wire logic        dv_n_i,
    input  wire logic [15:0] data_i,
    input  wire logic [3:0]  waits_i,
    output logic      [15:0] data_o,
    output logic             ack_upper_n_o,
    output logic             ack_lower_n_o
);
    logic [7:0]  mem [0:255];
    logic [15:0] bus;
    logic [3:0]  cnt;
    logic        p8;
    logic [7:0]  a;
    assign p8 = address_i[23]; // upper half of the map is the 8-bit port
    assign a = address_i[7:0];
    assign data_o = bus;
    // ack after waits_i cycles, held until the strobes rise; writes land with the ack
    always_ff @(posedge clock_i) begin
        if (av_n_i || dv_n_i) begin
            cnt <= 4'h0;
            ack_upper_n_o <= 1'b1;
            ack_lower_n_o <= 1'b1;
        end else if (cnt != waits_i) begin
            cnt <= cnt + 4'h1;
        end else if (ack_upper_n_o && ack_lower_n_o) begin
            ack_upper_n_o <= p8;
            ack_lower_n_o <= !p8;
            // an 8-bit port owns the upper lane only
            if (!read_write_i && (p8 || !a[0])) mem[a] <= data_i[15:8];
            if (!read_write_i && !p8 && (a[0] || size_i != 2'h1)) mem[a | 8'h01] <= data_i[7:0];
        end
    end
    // an undriven lane toggles, so a stale copy can never pass for data
    always_ff @(posedge clock_i) begin
        if (!dv_n_i && read_write_i) begin
            bus <= p8 ? {mem[a], ~bus[7:0]} : {mem[a & 8'hFE], mem[a | 8'h01]};
        end else begin
            bus <= ~bus;
        end
    end
endmodule

// ### verif/ebs_bus_master_tb.sv
// ebs_bus_master_tb: self-checking bench for the sizing bus master
`timescale 1ns/1ps
module ebs_bus_master_tb;
    import ebs_pkg::*;
    logic        clock_i, reset_i, req_valid_i, req_ready_o, resp_valid_o, exception_o;
    logic        read_write_o, av_n, dv_n, data_oe_o, hi, lo, ack_u_n, ack_l_n;
    logic        fault_n, halt_n, vec_n, mon, oe_dv;
    logic [23:0] address_o, la;
    logic [15:0] data_o, data_i, szs;
    logic [3:0]  waits;
    ebs_req_t    req_i;
    ebs_resp_t   resp_o;
    int          num_errors, samples_checked, nas, nexc, cyc;
    time         t_av, t_dv;

    ebs_bus_master DUT (
        .clock_i, .reset_i, .req_valid_i, .req_i, .req_ready_o, .resp_valid_o, .resp_o,
        .exception_o, .address_o, .xfer_size_code_hi_o(hi), .xfer_size_code_lo_o(lo),
        .read_write_o, .address_valid_strobe_n_o(av_n), .data_valid_strobe_n_o(dv_n),
        .data_o, .data_oe_o, .data_i, .port_ack_upper_n_i(ack_u_n),
        .port_ack_lower_n_i(ack_l_n), .bus_fault_term_n_i(fault_n), .halt_n_i(halt_n),
        .auto_vector_term_n_i(vec_n), .monitor_fault_i(mon)
    );
    ebs_mem_model partner (
        .clock_i, .address_i(address_o), .size_i({hi, lo}), .read_write_i(read_write_o),
        .av_n_i(av_n), .dv_n_i(dv_n), .data_i(data_o), .waits_i(waits), .data_o(data_i),
        .ack_upper_n_o(ack_u_n), .ack_lower_n_o(ack_l_n)
    );
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // log each bus cycle: count, size code history, address, strobe times
    always @(negedge av_n) begin
        nas++;
        szs = {szs[13:0], hi, lo};
        la = address_o;
        t_av = $time;
    end
    always @(negedge dv_n) begin
        t_dv = $time;
        oe_dv = data_oe_o;
    end
    // exception pulses and the hang limit, far above the few hundred cycles needed
    always @(posedge clock_i) begin
        cyc++;
        if (exception_o === 1'b1) nexc++;
        if (cyc > 20000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one operand through the request port; inputs move 2 ns after the edge
    task automatic run(input logic [23:0] a, input logic [2:0] n, input logic w, ia,
                       input logic [31:0] wd);
        int k;
        nas = 0;
        req_i = '{a, n, w, ia, wd};
        req_valid_i = 1'b1;
        for (k = 0; k < 50 && req_ready_o !== 1'b1; k++) begin
            @(posedge clock_i);
            #2;
        end
        @(posedge clock_i);
        #2;
        req_valid_i = 1'b0;
        for (k = 0; k < 300 && resp_valid_o !== 1'b1; k++) begin
            @(posedge clock_i);
            #2;
        end
        check(resp_valid_o, 1'b1);
    endtask
    task automatic t_word16();
        waits = 4'h1;
        run(24'h000010, 3'h2, 1'b1, 1'b0, 32'h0000A1B2);
        check(nas, 1);
        check(szs[1:0], SIZE_WORD);
        check(32'(t_dv - t_av), 32'd50);
        check(oe_dv, 1'b1);
        run(24'h000010, 3'h2, 1'b0, 1'b0, 32'h0);
        check(32'(t_dv - t_av), 32'd0);
        check(resp_o.rdata, 32'h0000A1B2);
        $display("word on 16-bit port done");
    endtask
    task automatic t_long8();
        waits = 4'h2;
        run(24'h800020, 3'h4, 1'b1, 1'b0, 32'h11223344);
        check(nas, 4);
        check(szs[7:0], 8'h39);
        check(la, 24'h800023);
        run(24'h800020, 3'h4, 1'b0, 1'b0, 32'h0);
        check(resp_o.rdata, 32'h11223344);
        run(24'h800021, 3'h1, 1'b0, 1'b0, 32'h0);
        check(resp_o.rdata, 32'h00000022);
        $display("long on 8-bit port done");
    endtask
    task automatic t_long16();
        waits = 4'h0;
        run(24'h000040, 3'h4, 1'b1, 1'b0, 32'hCAFE1234);
        check(nas, 2);
        check(szs[3:0], 4'h2);
        check(la, 24'h000042);
        run(24'h000041, 3'h1, 1'b0, 1'b0, 32'h0);
        check(resp_o.rdata, 32'h000000FE);
        run(24'h000040, 3'h4, 1'b0, 1'b0, 32'h0);
        check(resp_o.rdata, 32'hCAFE1234);
        $display("long on 16-bit port done");
    endtask
    // odd word and odd long must never reach the bus; an unsupported length must be refused
    task automatic t_misalign();
        run(24'h000011, 3'h2, 1'b0, 1'b0, 32'h0);
        check({resp_o.misalign, nas[7:0]}, 9'h100);
        run(24'h000013, 3'h4, 1'b1, 1'b0, 32'h0);
        check({resp_o.misalign, nas[7:0]}, 9'h100);
        run(24'h000010, 3'h3, 1'b0, 1'b0, 32'h0);
        check(resp_o.misalign, 1'b1);
        $display("misaligned refusals done");
    endtask
    // pass 0: external fault with halt; pass 1: internal monitor fault alone
    task automatic t_fault();
        int i;
        waits = 4'hF;
        for (i = 0; i < 2; i++) begin
            nexc = 0;
            fork
                run(24'h000050, 3'h2, 1'b0, 1'b0, 32'h0);
                begin
                    @(negedge av_n);
                    @(posedge clock_i);
                    #2;
                    fault_n = (i != 0);
                    halt_n = (i != 0);
                    mon = (i == 1);
                    @(posedge av_n);
                    #2;
                    fault_n = 1'b1;
                    halt_n = 1'b1;
                    mon = 1'b0;
                end
            join
            repeat (2) @(posedge clock_i);
            #2;
            check({resp_o.fault, nas[7:0]}, 9'h101);
            check(nexc, (i == 0) ? 1 : 0);
        end
        $display("bus fault termination done");
    endtask
    // auto-vector held low: ends the acknowledge cycle, ignored by an ordinary read
    task automatic t_vec();
        vec_n = 1'b0;
        waits = 4'hF;
        run(24'h000060, 3'h1, 1'b0, 1'b1, 32'h0);
        check({resp_o.autovec, nas[7:0]}, 9'h101);
        waits = 4'h0;
        run(24'h000010, 3'h1, 1'b0, 1'b0, 32'h0);
        check({resp_o.autovec, resp_o.rdata[7:0]}, 9'h0A1);
        vec_n = 1'b1;
        $display("auto-vector done");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {num_errors, samples_checked, nas, nexc, cyc} = '0;
        {reset_i, fault_n, halt_n, vec_n} = 4'hF;
        {req_valid_i, mon, szs, waits, req_i} = '0;
        repeat (2) @(posedge clock_i);
        #2;
        reset_i = 1'b0;
        @(posedge clock_i);
        #2;
        check({av_n, dv_n, data_oe_o, read_write_o, hi, lo}, 6'h34);
        t_word16();
        t_long8();
        t_long16();
        t_misalign();
        t_fault();
        t_vec();
        summarize();
    end
endmodule
